// file: shared/gfm_pkg.sv
// Overview of operation
// - Direction enables gate input and output use.
// - Channel functions act on selected channels.
// - Mapped pin disables matching software trigger, except the unlock key.
// - Boot samples pin level once, then edges.
// - Code 0010 falling edge dumps faults.
// - Code 0011 edges toggle current output power.
// - Code 0100 edges toggle voltage output power.
// - Code 0101 falling edge triggers protection.
// - Code 0111 falling edge clears outputs.
// - Code 1000 falling edge loads synchronous channels.
// - Code 1001 rise starts, fall stops waveforms.
// - Code 1010 rise margin high, fall low.
// - Code 1011 low pulse resets if stored.
// - Code 1100 fall allows, rise blocks programming.
// - Code 1101 falling edge re-enables register writes.
// - Code 1101 rise blocks writes except unlock, reset.
// - Output codes select busy or window status.
package gfm_pkg;
   localparam int NCH = 2;
   // Register byte addresses.
   localparam logic [7:0] CONFIG_OFS = 8'h00;
   localparam logic [7:0] CHAN_OFS = 8'h04;
   localparam logic [7:0] TRIG_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;
   // Pin configuration register layout, bits 15..0.
   typedef struct packed {
      logic nvm_stored;
      logic rsv;
      logic output_direction_enable;
      logic [3:0] output_status_code;
      logic [3:0] input_channel_select;
      logic [3:0] input_function_code;
      logic input_direction_enable;
   } gfm_cfg_t;
   localparam gfm_cfg_t CFG_RESET = '0;
   // Channel configuration register fields.
   localparam int CH_SYNC_LSB = 0;
   localparam int CH_VPDM_LSB = 2;
   localparam int CH_IPD_LSB = 6;
   localparam int CH_VPD_LSB = 8;
   localparam int CH_NVM_BIT = 10;
   localparam int CH_LOCK_BIT = 11;
   // Software trigger register fields.
   localparam int TR_FDUMP_BIT = 0;
   localparam int TR_PROT_BIT = 1;
   localparam int TR_CLR_BIT = 2;
   localparam int TR_LOAD_BIT = 3;
   localparam int TR_START_LSB = 4;
   localparam int TR_MHI_LSB = 6;
   localparam int TR_MLO_LSB = 8;
   localparam int TR_STOP_LSB = 10;
   localparam int TR_UNLOCK_LSB = 12;
   localparam int TR_RESET_LSB = 16;
   localparam logic [3:0] UNLOCK_KEY = 4'hA;
   localparam logic [3:0] RESET_KEY = 4'hA;
   // Input function codes.
   localparam logic [3:0] IN_FAULT_DUMP = 4'h2;
   localparam logic [3:0] IN_CURRENT_OUTPUT_PD = 4'h3;
   localparam logic [3:0] IN_VOLTAGE_OUTPUT_PD = 4'h4;
   localparam logic [3:0] IN_PROTECT = 4'h5;
   localparam logic [3:0] IN_CLEAR = 4'h7;
   localparam logic [3:0] IN_SYNC_LOAD = 4'h8;
   localparam logic [3:0] IN_FUNC_GEN = 4'h9;
   localparam logic [3:0] IN_MARGIN = 4'hA;
   localparam logic [3:0] IN_RESET = 4'hB;
   localparam logic [3:0] IN_NVM_GATE = 4'hC;
   localparam logic [3:0] IN_WRITE_LOCK = 4'hD;
   // Output status codes.
   localparam logic [3:0] OUT_NONVOLATILE_BUSY_FLAG = 4'h1;
   localparam logic [3:0] OUT_CH1_BUSY = 4'h4;
   localparam logic [3:0] OUT_CH0_BUSY = 4'h7;
   localparam logic [3:0] OUT_CH1_WIN = 4'h8;
   localparam logic [3:0] OUT_CH0_WIN = 4'hB;
   // Pin synchroniser settle time before the boot sample.
   localparam logic [1:0] BOOT_SETTLE = 2'h2;
   // One-cycle action pulses towards the converter core.
   typedef struct packed {
      logic fault_dump;
      logic protect;
      logic output_clear_action;
      logic device_reset;
      logic [NCH-1:0] synchronous_load;
      logic [NCH-1:0] margin_high;
      logic [NCH-1:0] margin_low;
   } gfm_act_t;
endpackage : gfm_pkg

// file: hw/gfm_pin_sync.sv
`timescale 1ns/100ps
module gfm_pin_sync #(
   parameter int STAGES = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin_in,
   output logic level,
   output logic boot,
   output logic boot_done,
   output logic rise,
   output logic fall
);
   import gfm_pkg::*;
   logic [STAGES-1:0] chain;
   logic [1:0] settle;
   // Synchroniser chain; only the last stage is looked at.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chain <= '0;
      end else begin
         chain <= {chain[STAGES-2:0], pin_in};
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level <= 1'b0;
      end else begin
         level <= chain[STAGES-1];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         settle <= 2'h0;
         boot <= 1'b0;
         boot_done <= 1'b0;
      end else begin
         boot <= 1'b0;
         if (!boot_done) begin
            settle <= settle + 2'h1;
            if (settle == BOOT_SETTLE) begin
               boot <= 1'b1;
               boot_done <= 1'b1;
            end
         end
      end
   end
   always_comb begin
      rise = boot_done && !boot && !level && chain[STAGES-1];
      fall = boot_done && !boot && level && !chain[STAGES-1];
   end
endmodule : gfm_pin_sync

// file: hw/gfm_gpio_mapper.sv
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
module gfm_gpio_mapper (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic gpio_in,
   output logic gpio_out,
   output logic gpio_oe,
   input wire logic nonvolatile_busy_flag,
   input wire logic [gfm_pkg::NCH-1:0] dac_busy,
   input wire logic channel_one_window_result,
   input wire logic channel_zero_window_result,
   output gfm_pkg::gfm_act_t act,
   output logic [gfm_pkg::NCH-1:0] current_output_powerdown,
   output logic [gfm_pkg::NCH-1:0] voltage_output_powerdown,
   output logic [2*gfm_pkg::NCH-1:0] voltage_powerdown_mode,
   output logic [gfm_pkg::NCH-1:0] func_gen_run,
   output logic nvm_program_enable,
   output logic register_write_lock
);
   import gfm_pkg::*;
   gfm_cfg_t cfg;
   logic [NCH-1:0] sync_config;
   logic dp_wr;
   logic dp_rd;
   logic [7:0] dp_addr;
   logic ap_take;
   logic pin_level;
   logic boot;
   logic boot_done;
   logic pin_rise;
   logic pin_fall;
   logic ev_rise;
   logic ev_fall;
   logic [NCH-1:0] chsel;
   logic [3:0] code;
   logic wr_cfg;
   logic wr_chan;
   logic wr_trig;
   logic unlock_wr;
   logic [NCH-1:0] sw_start;
   logic [NCH-1:0] sw_stop;
   gfm_act_t next_act;
   logic next_gpio_out;
   logic [31:0] next_rdata;

   gfm_pin_sync #(
      .STAGES(2)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(gpio_in),
      .level(pin_level),
      .boot(boot),
      .boot_done(boot_done),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   always_comb begin
      ev_rise = cfg.input_direction_enable && (pin_rise || (boot && pin_level));
      ev_fall = cfg.input_direction_enable && (pin_fall || (boot && !pin_level));
      chsel = cfg.input_channel_select[NCH-1:0];
      code = cfg.input_direction_enable ? cfg.input_function_code : 4'h0;
   end

   // Bus address phase and read wait state.
   always_comb begin
      ap_take = hsel && htrans[1] && hready;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         dp_wr <= ap_take && hwrite;
         dp_rd <= ap_take && !hwrite;
         if (ap_take) begin
            dp_addr <= {haddr[7:2], 2'b00};
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
      end else begin
         hreadyout <= !(ap_take && !hwrite);
         hresp <= 1'b0;
         if (dp_rd) begin
            hrdata <= next_rdata;
         end
      end
   end

   always_comb begin
      wr_cfg = dp_wr && (dp_addr == CONFIG_OFS) && !register_write_lock;
      wr_chan = dp_wr && (dp_addr == CHAN_OFS) && !register_write_lock;
      wr_trig = dp_wr && (dp_addr == TRIG_OFS) && !register_write_lock;
      unlock_wr = dp_wr && (dp_addr == TRIG_OFS) && (hwdata[TR_UNLOCK_LSB +: 4] == UNLOCK_KEY);
      sw_start = wr_trig ? hwdata[TR_START_LSB +: NCH] : '0;
      sw_stop = wr_trig ? hwdata[TR_STOP_LSB +: NCH] : '0;
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (dp_addr)
         CONFIG_OFS: next_rdata = {16'h0000, cfg};
         CHAN_OFS: begin
            next_rdata[CH_SYNC_LSB +: NCH] = sync_config;
            next_rdata[CH_VPDM_LSB +: 2*NCH] = voltage_powerdown_mode;
            next_rdata[CH_IPD_LSB +: NCH] = current_output_powerdown;
            next_rdata[CH_VPD_LSB +: NCH] = voltage_output_powerdown;
            next_rdata[CH_NVM_BIT] = nvm_program_enable;
            next_rdata[CH_LOCK_BIT] = register_write_lock;
         end
         STATUS_OFS: next_rdata = {22'h000000, register_write_lock, nvm_program_enable, func_gen_run,
                                   voltage_output_powerdown, current_output_powerdown, boot_done, pin_level};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg <= hwdata[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_config <= '0;
         voltage_powerdown_mode <= '0;
      end else if (wr_chan) begin
         sync_config <= hwdata[CH_SYNC_LSB +: NCH];
         voltage_powerdown_mode <= hwdata[CH_VPDM_LSB +: 2*NCH];
      end
   end

   // Current output power state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         current_output_powerdown <= '0;
      end else if (code == IN_CURRENT_OUTPUT_PD) begin
         if (ev_fall) begin
            current_output_powerdown <= current_output_powerdown | chsel;
         end else if (ev_rise) begin
            current_output_powerdown <= current_output_powerdown & ~chsel;
         end
      end else if (wr_chan) begin
         current_output_powerdown <= hwdata[CH_IPD_LSB +: NCH];
      end
   end

   // Voltage output power state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         voltage_output_powerdown <= '0;
      end else if (code == IN_VOLTAGE_OUTPUT_PD) begin
         if (ev_fall) begin
            voltage_output_powerdown <= voltage_output_powerdown | chsel;
         end else if (ev_rise) begin
            voltage_output_powerdown <= voltage_output_powerdown & ~chsel;
         end
      end else if (wr_chan) begin
         voltage_output_powerdown <= hwdata[CH_VPD_LSB +: NCH];
      end
   end

   // Waveform generator run state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         func_gen_run <= '0;
      end else if (code == IN_FUNC_GEN) begin
         if (ev_rise) begin
            func_gen_run <= func_gen_run | chsel;
         end else if (ev_fall) begin
            func_gen_run <= func_gen_run & ~chsel;
         end
      end else begin
         func_gen_run <= (func_gen_run & ~sw_stop) | sw_start;
      end
   end

   // Programming permission.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nvm_program_enable <= 1'b0;
      end else if (code == IN_NVM_GATE) begin
         if (ev_fall) begin
            nvm_program_enable <= 1'b1;
         end else if (ev_rise) begin
            nvm_program_enable <= 1'b0;
         end
      end else if (wr_chan) begin
         nvm_program_enable <= hwdata[CH_NVM_BIT];
      end
   end

   // Register write lock; a locking event wins over a same-cycle unlock.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         register_write_lock <= 1'b0;
      end else if (code == IN_WRITE_LOCK) begin
         if (ev_rise) begin
            register_write_lock <= 1'b1;
         end else if (ev_fall || unlock_wr) begin
            register_write_lock <= 1'b0;
         end
      end else if (wr_chan && hwdata[CH_LOCK_BIT]) begin
         register_write_lock <= 1'b1;
      end else if (unlock_wr) begin
         register_write_lock <= 1'b0;
      end
   end

   // Action pulses; software triggers pass only when the pin does not own them.
   always_comb begin
      next_act = '0;
      if (wr_trig) begin
         next_act.fault_dump = hwdata[TR_FDUMP_BIT] && (code != IN_FAULT_DUMP);
         next_act.protect = hwdata[TR_PROT_BIT] && (code != IN_PROTECT);
         next_act.output_clear_action = hwdata[TR_CLR_BIT] && (code != IN_CLEAR);
         if (code != IN_SYNC_LOAD) begin
            next_act.synchronous_load = hwdata[TR_LOAD_BIT] ? sync_config : '0;
         end
         if (code != IN_MARGIN) begin
            next_act.margin_high = hwdata[TR_MHI_LSB +: NCH];
            next_act.margin_low = hwdata[TR_MLO_LSB +: NCH];
         end
      end
      if (dp_wr && (dp_addr == TRIG_OFS) && (hwdata[TR_RESET_LSB +: 4] == RESET_KEY) && (code != IN_RESET)) begin
         next_act.device_reset = 1'b1;
      end
      unique case (code)
         IN_FAULT_DUMP: next_act.fault_dump = ev_fall;
         IN_PROTECT: next_act.protect = ev_fall;
         IN_CLEAR: next_act.output_clear_action = ev_fall;
         IN_SYNC_LOAD: next_act.synchronous_load = ev_fall ? (chsel & sync_config) : '0;
         IN_MARGIN: begin
            next_act.margin_high = ev_rise ? chsel : '0;
            next_act.margin_low = ev_fall ? chsel : '0;
         end
         IN_RESET: next_act.device_reset = pin_fall && cfg.nvm_stored;
         default: ;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act <= '0;
      end else begin
         act <= next_act;
      end
   end

   always_comb begin
      unique case (cfg.output_status_code)
         OUT_NONVOLATILE_BUSY_FLAG: next_gpio_out = nonvolatile_busy_flag;
         OUT_CH1_BUSY: next_gpio_out = dac_busy[1];
         OUT_CH0_BUSY: next_gpio_out = dac_busy[0];
         OUT_CH1_WIN: next_gpio_out = channel_one_window_result;
         OUT_CH0_WIN: next_gpio_out = channel_zero_window_result;
         default: next_gpio_out = 1'b0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gpio_out <= 1'b0;
         gpio_oe <= 1'b0;
      end else begin
         gpio_out <= cfg.output_direction_enable && !cfg.input_direction_enable && next_gpio_out;
         gpio_oe <= cfg.output_direction_enable && !cfg.input_direction_enable;
      end
   end
endmodule : gfm_gpio_mapper

// file: verif/gfm_gpio_mapper_sva.sv
`timescale 1ns/100ps
module gfm_gpio_mapper_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hwdata,
   input wire logic gpio_in,
   input wire logic gpio_out,
   input wire logic gpio_oe,
   input wire gfm_pkg::gfm_act_t act,
   input wire logic register_write_lock
);
   import gfm_pkg::*;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   chk_out_gated: assert property (!gpio_oe |-> !gpio_out)
      else $error("status pin high while released");
   chk_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read answer timing wrong");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   chk_reset_single: assert property (act.device_reset |=> !act.device_reset)
      else $error("reset pulse too long");
   chk_clear_single: assert property (act.output_clear_action |=> !act.output_clear_action)
      else $error("clear pulse too long");
   chk_margin_excl: assert property (!(|(act.margin_high & act.margin_low)))
      else $error("margin high and low together");
   chk_unlock_cause: assert property ($fell(register_write_lock) |-> !$past(gpio_in, 3) || $past(hwdata[15:12]) == UNLOCK_KEY)
      else $error("lock cleared without cause");
   chk_lock_cause: assert property ($rose(register_write_lock) |-> $past(gpio_in, 3) || $past(hwdata[11]))
      else $error("lock set without cause");
   cover property (act.fault_dump);
   cover property (gpio_oe && gpio_out);
   cover property ($rose(register_write_lock));
endmodule : gfm_gpio_mapper_chk

bind gfm_gpio_mapper gfm_gpio_mapper_chk i_gfm_gpio_mapper_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hwdata(hwdata),
   .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .act(act), .register_write_lock(register_write_lock));

// file: verif/gfm_pin_model.sv
`timescale 1ns/100ps
module gfm_pin_model (
   input wire logic drive_level,
   input wire logic gpio_out,
   input wire logic gpio_oe,
   output logic pin
);
   // Outside pin driver.
   // The outside logic lets go of the pin whenever the block drives it.
   assign pin = gpio_oe ? gpio_out : drive_level;
endmodule : gfm_pin_model

// file: verif/gfm_gpio_mapper_tb_top.sv
`timescale 1ns/100ps
module gfm_gpio_mapper_tb_top;
   import gfm_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [4:0] st = 5'h00;
   logic pin_drive = 1'b1;
   logic hreadyout, hresp, gpio_in, gpio_out, gpio_oe, nvm_en, lock;
   logic [31:0] hrdata, rd;
   logic [1:0] cur_pd, volt_pd, fg_run;
   logic [3:0] vpd_mode;
   logic [9:0] acc;
   gfm_act_t act;
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #5 hclk = ~hclk;
   gfm_gpio_mapper i_gfm_gpio_mapper (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gpio_in(gpio_in), .gpio_out(gpio_out),
      .gpio_oe(gpio_oe), .nonvolatile_busy_flag(st[4]), .dac_busy(st[3:2]), .channel_one_window_result(st[1]),
      .channel_zero_window_result(st[0]), .act(act), .current_output_powerdown(cur_pd),
      .voltage_output_powerdown(volt_pd), .voltage_powerdown_mode(vpd_mode), .func_gen_run(fg_run),
      .nvm_program_enable(nvm_en), .register_write_lock(lock));
   gfm_pin_model i_gfm_pin_model (.drive_level(pin_drive), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin(gpio_in));
   task stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         stop_test();
      end
   end
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   task ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   function automatic logic [31:0] mkcfg(input logic [3:0] ic, input logic [1:0] cs, input logic nv,
                                         input logic ie, input logic [3:0] oc, input logic oe);
      return {16'h0, nv, 1'b0, oe, oc, 2'b00, cs, ic, ie};
   endfunction : mkcfg
   task acc_act(input int n);
      acc = 10'h0;
      repeat (n) begin
         @(posedge hclk);
         acc = acc | act;
      end
   endtask : acc_act
   task step(input logic [3:0] ic, input logic p, input logic [9:0] ea, input logic [7:0] el,
             input logic [1:0] cs = 2'h3, input logic nv = 1'b0);
      ahb(CONFIG_OFS, 1'b1, mkcfg(ic, cs, nv, 1'b1, 4'h0, 1'b0));
      pin_drive <= p;
      acc_act(8);
      chk("act", ea, acc);
      chk("levels", el, {cur_pd, volt_pd, fg_run, nvm_en, lock});
   endtask : step
   task out_scen;
      logic [3:0] codes [6];
      codes = '{OUT_NONVOLATILE_BUSY_FLAG, OUT_CH1_BUSY, OUT_CH0_BUSY, OUT_CH1_WIN, OUT_CH0_WIN, 4'h2};
      for (int k = 0; k < 6; k++) begin
         ahb(CONFIG_OFS, 1'b1, mkcfg(4'h0, 2'h0, 1'b0, 1'b0, codes[k], 1'b1));
         for (int s = 0; s < 5; s++) begin
            st <= 5'h10 >> s;
            repeat (2) @(posedge hclk);
            chk("status pin", {k == s, 1'b1}, {gpio_out, gpio_oe});
         end
      end
      st <= 5'h1F;
      ahb(CONFIG_OFS, 1'b1, 32'h0);
      repeat (2) @(posedge hclk);
      chk("released pin", 2'b00, {gpio_out, gpio_oe});
   endtask : out_scen
   task sw_scen;
      ahb(CONFIG_OFS, 1'b1, mkcfg(IN_FAULT_DUMP, 2'h3, 1'b0, 1'b0, 4'h0, 1'b0));
      pin_drive <= 1'b0;
      acc_act(8);
      chk("act input off", 10'h0, acc);
      pin_drive <= 1'b1;
      ahb(CONFIG_OFS, 1'b1, mkcfg(IN_FAULT_DUMP, 2'h3, 1'b0, 1'b1, 4'h0, 1'b0));
      ahb(TRIG_OFS, 1'b1, 32'h1);
      acc_act(3);
      chk("soft dump mapped", 10'h0, acc);
      ahb(CONFIG_OFS, 1'b1, 32'h0);
      ahb(TRIG_OFS, 1'b1, 32'h1);
      acc_act(3);
      chk("soft dump", 10'h200, acc);
   endtask : sw_scen
   task lock_scen;
      ahb(CONFIG_OFS, 1'b1, 32'h0);
      ahb(CONFIG_OFS, 1'b0, 32'h0);
      chk("config locked", mkcfg(IN_WRITE_LOCK, 2'h3, 1'b0, 1'b1, 4'h0, 1'b0), rd);
      ahb(STATUS_OFS, 1'b0, 32'h0);
      chk("status locked", 32'h203, rd);
      ahb(TRIG_OFS, 1'b1, {12'h0, RESET_KEY, 16'h0001});
      acc_act(2);
      chk("reset field locked", 10'h040, acc);
      ahb(TRIG_OFS, 1'b1, {16'h0, UNLOCK_KEY, 12'h0});
      acc_act(2);
      chk("lock after key", 1'b0, lock);
   endtask : lock_scen
   // Boot level sample after a second reset.
   task boot_scen;
      pin_drive <= 1'b0;
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(CONFIG_OFS, 1'b1, mkcfg(IN_CURRENT_OUTPUT_PD, 2'h3, 1'b0, 1'b1, 4'h0, 1'b0));
      acc_act(4);
      chk("boot level", 8'hC0, {cur_pd, volt_pd, fg_run, nvm_en, lock});
      pin_drive <= 1'b1;
      acc_act(8);
      chk("edge after boot", 8'h00, {cur_pd, volt_pd, fg_run, nvm_en, lock});
   endtask : boot_scen
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(CONFIG_OFS, 1'b0, 32'h0);
      chk("config reset", {16'h0, CFG_RESET}, rd);
      ahb(8'h10, 1'b1, 32'hFFFFFFFF);
      ahb(8'h10, 1'b0, 32'h0);
      chk("unmapped read", 32'h0, rd);
      ahb(CHAN_OFS, 1'b1, 32'h9);
      ahb(CHAN_OFS, 1'b0, 32'h0);
      chk("chan read", 32'h9, rd);
      step(IN_FAULT_DUMP, 1'b0, 10'h200, 8'h00);
      chk("voltage_output mode", 4'h2, vpd_mode);
      step(IN_FAULT_DUMP, 1'b1, 10'h000, 8'h00);
      step(IN_PROTECT, 1'b0, 10'h100, 8'h00);
      step(IN_PROTECT, 1'b1, 10'h000, 8'h00);
      step(IN_CLEAR, 1'b0, 10'h080, 8'h00);
      step(IN_CLEAR, 1'b1, 10'h000, 8'h00);
      step(IN_SYNC_LOAD, 1'b0, 10'h010, 8'h00);
      step(IN_SYNC_LOAD, 1'b1, 10'h000, 8'h00);
      step(IN_MARGIN, 1'b0, 10'h002, 8'h00, 2'h2);
      step(IN_MARGIN, 1'b1, 10'h008, 8'h00, 2'h2);
      step(IN_RESET, 1'b0, 10'h000, 8'h00);
      step(IN_RESET, 1'b1, 10'h000, 8'h00);
      step(IN_RESET, 1'b0, 10'h040, 8'h00, 2'h3, 1'b1);
      step(IN_RESET, 1'b1, 10'h000, 8'h00, 2'h3, 1'b1);
      step(4'h6, 1'b0, 10'h000, 8'h00);
      step(4'h6, 1'b1, 10'h000, 8'h00);
      step(IN_CURRENT_OUTPUT_PD, 1'b0, 10'h000, 8'h40, 2'h1);
      step(IN_CURRENT_OUTPUT_PD, 1'b1, 10'h000, 8'h00, 2'h1);
      step(IN_VOLTAGE_OUTPUT_PD, 1'b0, 10'h000, 8'h20, 2'h2);
      step(IN_VOLTAGE_OUTPUT_PD, 1'b1, 10'h000, 8'h00, 2'h2);
      step(IN_FUNC_GEN, 1'b0, 10'h000, 8'h00);
      step(IN_FUNC_GEN, 1'b1, 10'h000, 8'h0C);
      step(IN_FUNC_GEN, 1'b0, 10'h000, 8'h00);
      step(IN_NVM_GATE, 1'b1, 10'h000, 8'h00);
      step(IN_NVM_GATE, 1'b0, 10'h000, 8'h02);
      step(IN_NVM_GATE, 1'b1, 10'h000, 8'h00);
      step(IN_WRITE_LOCK, 1'b0, 10'h000, 8'h00);
      step(IN_WRITE_LOCK, 1'b1, 10'h000, 8'h01);
      step(IN_WRITE_LOCK, 1'b0, 10'h000, 8'h00);
      step(IN_WRITE_LOCK, 1'b1, 10'h000, 8'h01);
      lock_scen();
      sw_scen();
      out_scen();
      boot_scen();
      stop_test();
   end
endmodule : gfm_gpio_mapper_tb_top
